// [ihw_hs_write_slave.sv]
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// What this block does
// - That code byte is never acknowledged, so the data line stays released in its ninth clock.
// - The address 10011 plus the two address pin bits with write low is matched and acknowledged by pulling data low.
// - One control byte follows the address, and it, every later data byte and the two power-down bytes are acknowledged.
// - The control byte holds zero, zero, two load bits, zero, two channel bits and the power-down select flag.
// - With the select flag low, high and low byte pairs are taken until a stop or repeated start.
// - With the select flag high, exactly two power-down bytes are taken, then the master ends the transfer.
// - The first byte of a pair carries code bits nine down to two, bit nine first.
// - The second byte of a pair carries code bits one and zero on top, the other six bits being ignored.
// - The first power-down byte carries the two mode bits in its top positions, the rest sent as zero.
// - The second power-down byte has its top two bits zero and its lower six bits ignored.
// - Each channel keeps a twelve-bit staging word, power-down bits on top and the code below.
// - Each channel keeps a twelve-bit output word of the same split, and loading it updates the output.
// - The control byte's channel bits pick which of the four channels is written.
module ihw_hs_write_slave (
	input  wire logic                        i_clk,
	input  wire logic                        i_rstn,
	input  wire logic                        i_ce,
	input  wire logic                        i_link_clk,
	input  wire logic                        i_scl,
	input  wire logic                        i_sda,
	output logic                             o_sda_out,
	output logic                             o_sda_oe,
	input  wire logic                        i_s_axi_awvalid,
	output logic                             o_s_axi_awready,
	input  wire logic [ihw_pkg::AXI_AW-1:0]  i_s_axi_awaddr,
	input  wire logic                        i_s_axi_wvalid,
	output logic                             o_s_axi_wready,
	input  wire logic [31:0]                 i_s_axi_wdata,
	input  wire logic [3:0]                  i_s_axi_wstrb,
	output logic                             o_s_axi_bvalid,
	input  wire logic                        i_s_axi_bready,
	output logic [1:0]                       o_s_axi_bresp,
	input  wire logic                        i_s_axi_arvalid,
	output logic                             o_s_axi_arready,
	input  wire logic [ihw_pkg::AXI_AW-1:0]  i_s_axi_araddr,
	output logic                             o_s_axi_rvalid,
	input  wire logic                        i_s_axi_rready,
	output logic [31:0]                      o_s_axi_rdata,
	output logic [1:0]                       o_s_axi_rresp,
	output logic [ihw_pkg::WORD_W-1:0]       o_out_word [ihw_pkg::NUM_CHAN],
	output logic                             o_update
);
	import ihw_pkg::*;

	// ==========================================================
	// Link domain: reset, enable and pin synchronisers
	logic       link_rst_sync;
	logic       link_rstn;
	logic       link_ce;
	logic [2:0] cfg_link;
	logic [1:0] pins_sync;
	logic [2:0] cfg_q;

	ihw_sync2 #(.W(1)) u_rst_sync (
		.i_clk  (i_link_clk),
		.i_rstn (1'b1),
		.i_ce   (1'b1),
		.i_d    (i_rstn),
		.o_q    (link_rst_sync)
	);
	assign link_rstn = link_rst_sync;

	ihw_sync2 #(.W(1)) u_ce_sync (
		.i_clk  (i_link_clk),
		.i_rstn (link_rstn),
		.i_ce   (1'b1),
		.i_d    (i_ce),
		.o_q    (link_ce)
	);

	ihw_sync2 #(.W(3)) u_cfg_sync (
		.i_clk  (i_link_clk),
		.i_rstn (link_rstn),
		.i_ce   (link_ce),
		.i_d    (cfg_q),
		.o_q    (cfg_link)
	);

	ihw_sync2 #(.W(2)) u_pin_sync (
		.i_clk  (i_link_clk),
		.i_rstn (link_rstn),
		.i_ce   (link_ce),
		.i_d    ({i_scl, i_sda}),
		.o_q    (pins_sync)
	);

	// ==========================================================
	// Link domain: byte receiver and transfer sequencer
	ihw_state_e  st_q, st_d;
	logic        scl_q, scl_d, sda_q, sda_d;
	logic        hs_q, hs_d;
	logic [2:0]  cnt_q, cnt_d;
	logic [6:0]  sh_q, sh_d;
	logic        pend_q, pend_d;
	logic        ackph_q, ackph_d;
	logic        ackw_q, ackw_d;
	logic        drv_q, drv_d;
	logic [7:0]  ctrl_q, ctrl_d;
	logic        half_q, half_d;
	logic [7:0]  hi_q, hi_d;
	logic [1:0]  pdm_q, pdm_d;
	logic        ev_tgl_q, ev_tgl_d;
	logic [11:0] ev_word_q, ev_word_d;
	logic [1:0]  ev_chan_q, ev_chan_d;
	logic [1:0]  ev_load_q, ev_load_d;
	logic        ev_pd_q, ev_pd_d;
	logic        scl_rise, scl_fall, start_c, stop_c;
	logic [7:0]  rx_byte;

	assign scl_rise = pins_sync[1] && !scl_q;
	assign scl_fall = !pins_sync[1] && scl_q;
	assign start_c  = pins_sync[1] && scl_q && sda_q && !pins_sync[0];
	assign stop_c   = pins_sync[1] && scl_q && !sda_q && pins_sync[0];
	assign rx_byte  = {sh_q, pins_sync[0]};

	always_comb begin
		st_d      = st_q;
		scl_d     = pins_sync[1];
		sda_d     = pins_sync[0];
		hs_d      = hs_q;
		cnt_d     = cnt_q;
		sh_d      = sh_q;
		pend_d    = pend_q;
		ackph_d   = ackph_q;
		ackw_d    = ackw_q;
		drv_d     = drv_q;
		ctrl_d    = ctrl_q;
		half_d    = half_q;
		hi_d      = hi_q;
		pdm_d     = pdm_q;
		ev_tgl_d  = ev_tgl_q;
		ev_word_d = ev_word_q;
		ev_chan_d = ev_chan_q;
		ev_load_d = ev_load_q;
		ev_pd_d   = ev_pd_q;
		if (!cfg_link[CFG_ENABLE_BIT] || stop_c) begin
			// A stop drops back to normal speed
			st_d    = ST_IDLE;
			hs_d    = 1'b0;
			pend_d  = 1'b0;
			ackph_d = 1'b0;
			drv_d   = 1'b0;
		end else if (start_c) begin
			// Repeated start in high-speed mode goes straight to addressing; data streams end here
			st_d    = hs_q ? ST_ADDR : ST_FSBYTE;
			cnt_d   = '0;
			pend_d  = 1'b0;
			ackph_d = 1'b0;
			drv_d   = 1'b0;
		end else if (scl_rise && !pend_q && !ackph_q && st_q != ST_IDLE) begin
			sh_d  = rx_byte[6:0];
			cnt_d = 3'(cnt_q + 3'h1);
			if (cnt_q == LAST_BIT) begin
				pend_d = 1'b1;
				ackw_d = 1'b0;
				unique case (st_q)
					ST_FSBYTE: begin
						if (rx_byte[7:3] == MASTER_CODE_TOP) begin
							hs_d = 1'b1;
							st_d = ST_HS_WAIT;
						end else begin
							st_d = ST_IGNORE;
						end
					end
					ST_ADDR: begin
						if (rx_byte[7:3] == SLAVE_ADDR_TOP && rx_byte[2:1] == cfg_link[CFG_PIN_HI_BIT:CFG_PIN_LO_BIT]
							&& !rx_byte[0]) begin
							ackw_d = 1'b1;
							st_d   = ST_CTRL;
						end else begin
							st_d = ST_IGNORE;
						end
					end
					ST_CTRL: begin
						ackw_d = 1'b1;
						ctrl_d = rx_byte;
						half_d = 1'b0;
						st_d   = rx_byte[CTL_PDSEL_BIT] ? ST_PDN : ST_DATA;
					end
					ST_DATA: begin
						ackw_d = 1'b1;
						half_d = !half_q;
						if (!half_q) begin
							hi_d = rx_byte;
						end else begin
							ev_word_d = {2'b00, hi_q, rx_byte[7:6]};
							ev_pd_d   = 1'b0;
							ev_chan_d = ctrl_q[CTL_CHAN_LSB +: 2];
							ev_load_d = ctrl_q[CTL_LOAD_LSB +: 2];
							ev_tgl_d  = !ev_tgl_q;
						end
					end
					ST_PDN: begin
						ackw_d = 1'b1;
						half_d = 1'b1;
						if (!half_q) begin
							pdm_d = rx_byte[7:6];
						end else begin
							// Second byte is don't-care below its top bits; further bytes go unanswered
							ev_word_d = {pdm_q, 10'h000};
							ev_pd_d   = 1'b1;
							ev_chan_d = ctrl_q[CTL_CHAN_LSB +: 2];
							ev_load_d = ctrl_q[CTL_LOAD_LSB +: 2];
							ev_tgl_d  = !ev_tgl_q;
							st_d      = ST_IGNORE;
						end
					end
					ST_IDLE, ST_HS_WAIT, ST_IGNORE: begin
						ackw_d = 1'b0;
					end
				endcase
			end
		end else if (scl_fall) begin
			if (pend_q) begin
				pend_d  = 1'b0;
				ackph_d = 1'b1;
				drv_d   = ackw_q;
			end else if (ackph_q) begin
				ackph_d = 1'b0;
				drv_d   = 1'b0;
			end
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (!link_rstn) begin
			st_q      <= ST_IDLE;
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			hs_q      <= 1'b0;
			cnt_q     <= '0;
			sh_q      <= '0;
			pend_q    <= 1'b0;
			ackph_q   <= 1'b0;
			ackw_q    <= 1'b0;
			drv_q     <= 1'b0;
			ctrl_q    <= '0;
			half_q    <= 1'b0;
			hi_q      <= '0;
			pdm_q     <= '0;
			ev_tgl_q  <= 1'b0;
			ev_word_q <= WORD_RESET;
			ev_chan_q <= '0;
			ev_load_q <= '0;
			ev_pd_q   <= 1'b0;
		end else if (link_ce) begin
			st_q      <= st_d;
			scl_q     <= scl_d;
			sda_q     <= sda_d;
			hs_q      <= hs_d;
			cnt_q     <= cnt_d;
			sh_q      <= sh_d;
			pend_q    <= pend_d;
			ackph_q   <= ackph_d;
			ackw_q    <= ackw_d;
			drv_q     <= drv_d;
			ctrl_q    <= ctrl_d;
			half_q    <= half_d;
			hi_q      <= hi_d;
			pdm_q     <= pdm_d;
			ev_tgl_q  <= ev_tgl_d;
			ev_word_q <= ev_word_d;
			ev_chan_q <= ev_chan_d;
			ev_load_q <= ev_load_d;
			ev_pd_q   <= ev_pd_d;
		end
	end

	// Open drain: only ever pull low
	assign o_sda_out = 1'b0;
	assign o_sda_oe  = drv_q;

	// ==========================================================
	// Crossing into the register clock
	// The event payload is held for a whole byte time after its toggle,
	// far longer than the three register clocks needed to take it.
	logic [2:0] stat_sync;
	logic       tgl_seen_q, tgl_seen_d;

	ihw_sync2 #(.W(3)) u_stat_sync (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_ce   (i_ce),
		.i_d    ({ev_tgl_q, st_q != ST_IDLE, hs_q}),
		.o_q    (stat_sync)
	);

	// ==========================================================
	// Channel words and register bus
	logic [11:0] stg_q [NUM_CHAN];
	logic [11:0] stg_d [NUM_CHAN];
	logic [11:0] out_q [NUM_CHAN];
	logic [11:0] out_d [NUM_CHAN];
	logic [31:0] count_q, count_d;
	logic        upd_q, upd_d;
	logic [2:0]  cfg_d;
	logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
	logic [7:0]  awa_q, awa_d;
	logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d;
	logic        wstb_q, wstb_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [11:0] new_word;

	function automatic logic [2:0] decode(input logic [7:0] a);
		// [2]=mapped, [1]=channel word, [0]=output bank
		if (a == OFS_CFG || a == OFS_STATUS || a == OFS_COUNT) begin
			decode = 3'b100;
		end else if (a[7:4] == OFS_STG_BASE[7:4] && a[3:0] == {a[3:2], 2'b00}) begin
			decode = 3'b110;
		end else if (a[7:4] == OFS_OUT_BASE[7:4] && a[3:0] == {a[3:2], 2'b00}) begin
			decode = 3'b111;
		end else begin
			decode = 3'b000;
		end
	endfunction

	assign new_word = ev_pd_q ? {ev_word_q[11:10], stg_q[ev_chan_q][9:0]} : ev_word_q;

	always_comb begin
		logic [2:0] dw;
		logic [2:0] dr;
		dw         = decode(awa_q);
		dr         = decode(i_s_axi_araddr);
		stg_d      = stg_q;
		out_d      = out_q;
		count_d    = count_q;
		upd_d      = 1'b0;
		tgl_seen_d = stat_sync[2];
		cfg_d      = cfg_q;
		aw_d       = aw_q;
		w_d        = w_q;
		b_d        = b_q;
		r_d        = r_q;
		awa_d      = awa_q;
		wdat_d     = wdat_q;
		wstb_d     = wstb_q;
		bresp_d    = bresp_q;
		rresp_d    = rresp_q;
		rdat_d     = rdat_q;
		if (stat_sync[2] != tgl_seen_q) begin
			stg_d[ev_chan_q] = new_word;
			count_d          = 32'(count_q + 32'h1);
			if (ev_load_q == LOAD_ONE) begin
				out_d[ev_chan_q] = new_word;
				upd_d            = 1'b1;
			end else if (ev_load_q != LOAD_STAGE_ONLY) begin
				out_d            = stg_q;
				out_d[ev_chan_q] = new_word;
				upd_d            = 1'b1;
			end
		end
		if (i_s_axi_awvalid && !aw_q && !b_q) begin
			aw_d  = 1'b1;
			awa_d = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && !w_q && !b_q) begin
			w_d    = 1'b1;
			wdat_d = i_s_axi_wdata;
			wstb_d = i_s_axi_wstrb[0];
		end
		if (aw_q && w_q) begin
			aw_d    = 1'b0;
			w_d     = 1'b0;
			b_d     = 1'b1;
			bresp_d = dw[2] ? RESP_OKAY : RESP_SLVERR;
			// Only the configuration word is writable; the rest read back state
			if (awa_q == OFS_CFG && wstb_q) begin
				cfg_d = wdat_q[2:0];
			end
		end
		if (b_q && i_s_axi_bready) begin
			b_d = 1'b0;
		end
		if (i_s_axi_arvalid && !r_q) begin
			r_d     = 1'b1;
			rresp_d = dr[2] ? RESP_OKAY : RESP_SLVERR;
			rdat_d  = '0;
			if (dr[1]) begin
				rdat_d[11:0] = dr[0] ? out_q[i_s_axi_araddr[3:2]] : stg_q[i_s_axi_araddr[3:2]];
			end else if (i_s_axi_araddr == OFS_CFG) begin
				rdat_d[2:0] = cfg_q;
			end else if (i_s_axi_araddr == OFS_STATUS) begin
				rdat_d[STAT_HS_BIT]   = stat_sync[0];
				rdat_d[STAT_BUSY_BIT] = stat_sync[1];
			end else if (i_s_axi_araddr == OFS_COUNT) begin
				rdat_d = count_q;
			end
		end else if (r_q && i_s_axi_rready) begin
			r_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				stg_q[i] <= WORD_RESET;
				out_q[i] <= WORD_RESET;
			end
			count_q    <= '0;
			upd_q      <= 1'b0;
			tgl_seen_q <= 1'b0;
			cfg_q      <= CFG_RESET;
			aw_q       <= 1'b0;
			w_q        <= 1'b0;
			b_q        <= 1'b0;
			r_q        <= 1'b0;
			awa_q      <= '0;
			wdat_q     <= '0;
			wstb_q     <= 1'b0;
			bresp_q    <= RESP_OKAY;
			rresp_q    <= RESP_OKAY;
			rdat_q     <= '0;
		end else if (i_ce) begin
			stg_q      <= stg_d;
			out_q      <= out_d;
			count_q    <= count_d;
			upd_q      <= upd_d;
			tgl_seen_q <= tgl_seen_d;
			cfg_q      <= cfg_d;
			aw_q       <= aw_d;
			w_q        <= w_d;
			b_q        <= b_d;
			r_q        <= r_d;
			awa_q      <= awa_d;
			wdat_q     <= wdat_d;
			wstb_q     <= wstb_d;
			bresp_q    <= bresp_d;
			rresp_q    <= rresp_d;
			rdat_q     <= rdat_d;
		end
	end

	assign o_s_axi_awready = !aw_q && !b_q && i_ce;
	assign o_s_axi_wready  = !w_q && !b_q && i_ce;
	assign o_s_axi_bvalid  = b_q;
	assign o_s_axi_bresp   = bresp_q;
	assign o_s_axi_arready = !r_q && i_ce;
	assign o_s_axi_rvalid  = r_q;
	assign o_s_axi_rdata   = rdat_q;
	assign o_s_axi_rresp   = rresp_q;
	assign o_out_word      = out_q;
	assign o_update        = upd_q;

endmodule

// [ihw_hs_write_slave_props.sv]
`timescale 1ns/1ps
module ihw_hs_write_slave_props (
	input wire logic                        i_clk,
	input wire logic                        i_rstn,
	input wire logic                        i_link_clk,
	input wire logic                        i_scl,
	input wire logic                        o_sda_out,
	input wire logic                        o_sda_oe,
	input wire logic                        i_s_axi_awvalid,
	input wire logic                        o_s_axi_awready,
	input wire logic                        i_s_axi_wvalid,
	input wire logic                        o_s_axi_wready,
	input wire logic                        o_s_axi_bvalid,
	input wire logic                        i_s_axi_arvalid,
	input wire logic                        o_s_axi_arready,
	input wire logic                        o_s_axi_rvalid,
	input wire logic [1:0]                  o_s_axi_bresp,
	input wire logic [ihw_pkg::WORD_W-1:0]  o_out_word [ihw_pkg::NUM_CHAN],
	input wire logic                        o_update
);
	import ihw_pkg::*;
	logic [47:0] outs_flat;
	assign outs_flat = {o_out_word[3], o_out_word[2], o_out_word[1], o_out_word[0]};
	// ==========================================================
	// Link side: ack launched in the low phase, held across the high phase
	chk_ack_low_phase: assert property (@(posedge i_link_clk) disable iff (!i_rstn) $rose(o_sda_oe) |-> !i_scl)
		else $error("ack raised while clock high");
	chk_ack_holds: assert property (@(posedge i_link_clk) disable iff (!i_rstn) $rose(o_sda_oe) |=> o_sda_oe[*8])
		else $error("ack dropped early");
	chk_ack_ends: assert property (@(posedge i_link_clk) disable iff (!i_rstn) $rose(o_sda_oe) |-> ##[1:60] !o_sda_oe)
		else $error("ack never released");
	chk_sda_drain: assert property (@(posedge i_link_clk) disable iff (!i_rstn) o_sda_out == 1'b0)
		else $error("data pin driven high");
	// ==========================================================
	// Register bus and outputs
	chk_wr_answer: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid)
		else $error("write not answered");
	chk_aw_refused: assert property (@(posedge i_clk) disable iff (!i_rstn) o_s_axi_bvalid |-> !o_s_axi_awready)
		else $error("address taken with response pending");
	chk_rd_answer: assert property (@(posedge i_clk) disable iff (!i_rstn) i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read not answered");
	chk_ar_refused: assert property (@(posedge i_clk) disable iff (!i_rstn) o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read taken with data pending");
	chk_upd_pulse: assert property (@(posedge i_clk) disable iff (!i_rstn) o_update |=> !o_update)
		else $error("update pulse too long");
	chk_out_cause: assert property (@(posedge i_clk) disable iff (!i_rstn)
		outs_flat != $past(outs_flat) |-> (##[0:1] o_update) or $past(o_update))
		else $error("output word changed without update");
	cov_ack: cover property (@(posedge i_link_clk) disable iff (!i_rstn) $rose(o_sda_oe));
	cov_update: cover property (@(posedge i_clk) disable iff (!i_rstn) o_update);
	cov_slverr: cover property (@(posedge i_clk) disable iff (!i_rstn) o_s_axi_bvalid && o_s_axi_bresp == RESP_SLVERR);
endmodule
bind ihw_hs_write_slave ihw_hs_write_slave_props chk_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_link_clk(i_link_clk),
	.i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_s_axi_awvalid(i_s_axi_awvalid),
	.o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
	.o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
	.o_s_axi_rvalid(o_s_axi_rvalid), .o_s_axi_bresp(o_s_axi_bresp), .o_out_word(o_out_word), .o_update(o_update));

// [ihw_i2c_master_model.sv]
`timescale 1ns/1ps
module ihw_i2c_master_model (
	output logic      o_scl,
	output logic      o_sda_oe,
	input  wire logic i_sda
);
	int hp = 240;
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	// ==========================================================
	// Data moves late in the low phase so a slow ack release never collides
	task automatic bit_io(input logic b, output logic s);
		#(hp * 3 / 4) o_sda_oe = ~b;
		#(hp / 4) o_scl = 1'b1;
		#(hp / 2) s = i_sda;
		#(hp / 2) o_scl = 1'b0;
	endtask
	task automatic send(input logic [7:0] b, output logic ack_n);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, ack_n);
	endtask
	task automatic start();
		#(hp) o_sda_oe = 1'b1;
		#(hp) o_scl = 1'b0;
	endtask
	task automatic rstart();
		#(hp * 3 / 4) o_sda_oe = 1'b0;
		#(hp / 4) o_scl = 1'b1;
		#(hp / 2) o_sda_oe = 1'b1;
		#(hp / 2) o_scl = 1'b0;
	endtask
	task automatic stop();
		#(hp * 3 / 4) o_sda_oe = 1'b1;
		#(hp / 4) o_scl = 1'b1;
		#(hp) o_sda_oe = 1'b0;
		#(hp);
	endtask
endmodule

// [ihw_pkg.sv]
package ihw_pkg;

	// ==========================================================
	// Register bus
	localparam int          AXI_AW        = 8;
	localparam logic [7:0]  OFS_CFG       = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_COUNT     = 8'h08;
	localparam logic [7:0]  OFS_STG_BASE  = 8'h10;
	localparam logic [7:0]  OFS_OUT_BASE  = 8'h20;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ==========================================================
	// Configuration and status fields
	localparam int          CFG_ENABLE_BIT  = 0;
	localparam int          CFG_PIN_LO_BIT  = 1;
	localparam int          CFG_PIN_HI_BIT  = 2;
	localparam logic [2:0]  CFG_RESET       = 3'h0;
	localparam int          STAT_HS_BIT     = 0;
	localparam int          STAT_BUSY_BIT   = 1;

	// ==========================================================
	// Serial protocol
	localparam int          NUM_CHAN        = 4;
	localparam int          WORD_W          = 12;
	localparam logic [4:0]  MASTER_CODE_TOP = 5'h01;
	localparam logic [4:0]  SLAVE_ADDR_TOP  = 5'h13;
	localparam logic [2:0]  LAST_BIT        = 3'h7;
	localparam int          CTL_PDSEL_BIT   = 0;
	localparam int          CTL_CHAN_LSB    = 1;
	localparam int          CTL_LOAD_LSB    = 4;
	localparam logic [1:0]  LOAD_STAGE_ONLY = 2'h0;
	localparam logic [1:0]  LOAD_ONE        = 2'h1;
	localparam logic [11:0] WORD_RESET      = 12'h000;

	// Gray codes along the usual path through a transfer
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_FSBYTE  = 3'b001,
		ST_HS_WAIT = 3'b011,
		ST_ADDR    = 3'b010,
		ST_CTRL    = 3'b110,
		ST_DATA    = 3'b111,
		ST_PDN     = 3'b101,
		ST_IGNORE  = 3'b100
	} ihw_state_e;

endpackage

// [ihw_sync2.sv]
`timescale 1ns/1ps
module ihw_sync2 #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	// ==========================================================
	// Two-flop synchroniser; first stage feeds only the second
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = meta_q;
		sync_d = sync_q;
		if (!i_rstn) begin
			meta_d = '0;
			sync_d = '0;
		end else if (i_ce) begin
			meta_d = i_d;
			sync_d = meta_q;
		end
	end

	always_ff @(posedge i_clk) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign o_q = sync_q;

endmodule

// [test_ihw_hs_write_slave.sv]
`timescale 1ns/1ps
module test_ihw_hs_write_slave;
	import ihw_pkg::*;
	typedef struct {
		logic [7:0]  ctl;
		logic [7:0]  b1;
		logic [7:0]  b2;
		logic [7:0]  sa;
		logic [11:0] stg;
		logic [47:0] outs;
	} ihw_row_s;
	// Control byte: 0 0 load[1:0] 0 chan[1:0] pd_select
	ihw_row_s    rows [4] = '{'{8'h12, 8'hA5, 8'hD5, 8'h14, 12'h297, 48'h000000297000},
		'{8'h04, 8'h3C, 8'h7F, 8'h18, 12'h0F1, 48'h000000297000},
		'{8'h26, 8'hFF, 8'hC0, 8'h1C, 12'h3FF, 48'h3FF0F1297000},
		'{8'h11, 8'h80, 8'h15, 8'h10, 12'h800, 48'h3FF0F1297800}};
	logic        i_clk = 1'b0, i_rstn = 1'b0, lclk = 1'b0, ce = 1'b1;
	logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [3:0]  ws = 4'hF;
	wire         awr, wr, bv, arr, rv, scl, m_oe, d_out, d_oe, sda, upd;
	wire  [1:0]  br, rr;
	wire  [31:0] rd;
	wire  [11:0] ow [4];
	int          bad_count = 0, checks_done = 0;
	int          upd_n = 0;
	always #12.5 i_clk = ~i_clk;
	always begin
		#1.3;
		forever #3 lclk = ~lclk;
	end
	// Count update pulses so stage-only loads can be told apart from output loads
	always @(posedge i_clk) begin
		if (!i_rstn) upd_n <= 0;
		else if (upd === 1'b1) upd_n <= upd_n + 1;
	end
	// Pull-up on the data line; either side may pull it low
	assign sda = ~(m_oe | (d_oe & ~d_out));
	ihw_hs_write_slave dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_link_clk(lclk), .i_scl(scl),
		.i_sda(sda), .o_sda_out(d_out), .o_sda_oe(d_oe), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
		.o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br), .i_s_axi_arvalid(arv),
		.o_s_axi_arready(arr), .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
		.o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_out_word(ow), .o_update(upd));
	ihw_i2c_master_model m_u (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));
	// ==========================================================
	// Reporting
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic give_up();
		bad_count++;
		final_report();
	endtask
	// ==========================================================
	// Register bus master
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		@(posedge i_clk);
		awa <= a;
		wd <= d;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge i_clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			if (bv) break;
		end
		bry <= 1'b0;
		cmp_val(32'(br), 32'(er));
		if (n == 40) give_up();
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge i_clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge i_clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		rry <= 1'b0;
		cmp_val(rd, ed);
		cmp_val(32'(rr), 32'(er));
		if (n == 40) give_up();
	endtask
	// ==========================================================
	// Serial helpers
	task automatic snd(input logic [7:0] b, input logic nack);
		logic a;
		m_u.send(b, a);
		cmp_val(32'(a), 32'(nack));
	endtask
	task automatic snd_all(input logic [7:0] q[$]);
		foreach (q[i]) snd(q[i], 1'b0);
	endtask
	task automatic enter_hs();
		m_u.hp = 240;
		m_u.start();
		snd(8'h0D, 1'b1);
		m_u.hp = 80;
		m_u.rstart();
	endtask
	// Crossing back to the register clock takes a few cycles, so wait before looking
	task automatic chk_after(input logic [47:0] e, input logic [31:0] cnt);
		repeat (20) @(posedge i_clk);
		for (int c = 0; c < 4; c++) cmp_val(32'(ow[c]), 32'(e[c*12 +: 12]));
		rd_chk(OFS_COUNT, cnt, RESP_OKAY);
	endtask
	// ==========================================================
	// Sequence; address byte 10011 with pins 1 0 and write low is 9C
	initial begin
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		axi_wr(OFS_CFG, 32'h5, 4'hF, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			enter_hs();
			snd_all('{8'h9C, rows[i].ctl, rows[i].b1, rows[i].b2});
			m_u.stop();
			chk_after(rows[i].outs, 32'(i + 1));
			rd_chk(rows[i].sa, 32'(rows[i].stg), RESP_OKAY);
		end
		cmp_val(32'(upd_n), 32'h3);
		axi_wr(OFS_CFG, 32'h0, 4'h0, RESP_OKAY);
		rd_chk(OFS_CFG, 32'h5, RESP_OKAY);
		axi_wr(OFS_STATUS, 32'hFF, 4'hF, RESP_OKAY);
		rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
		axi_wr(OFS_STG_BASE, 32'hFFF, 4'hF, RESP_OKAY);
		rd_chk(OFS_STG_BASE, 32'h800, RESP_OKAY);
		axi_wr(8'h40, 32'h1, 4'hF, RESP_SLVERR);
		rd_chk(8'h40, 32'h0, RESP_SLVERR);
		enter_hs();
		rd_chk(OFS_STATUS, 32'h3, RESP_OKAY);
		snd_all('{8'h9C, 8'h14, 8'h01, 8'h40, 8'h80, 8'h00});
		m_u.rstart();
		snd_all('{8'h9C, 8'h16, 8'h00, 8'hC0, 8'hFF});
		m_u.stop();
		chk_after(48'h003200297800, 32'h7);
		enter_hs();
		snd_all('{8'h9C, 8'h35, 8'h40, 8'h2A});
		snd(8'h00, 1'b1);
		m_u.stop();
		chk_after(48'h003600297800, 32'h8);
		m_u.start();
		snd(8'h9C, 1'b1);
		m_u.stop();
		enter_hs();
		snd(8'h9E, 1'b1);
		m_u.rstart();
		snd(8'h9D, 1'b1);
		m_u.stop();
		chk_after(48'h003600297800, 32'h8);
		cmp_val(32'(upd_n), 32'h7);
		// Enable low must refuse new bus requests
		ce <= 1'b0;
		repeat (2) @(posedge i_clk);
		cmp_val(32'(arr), 32'h0);
		cmp_val(32'(awr), 32'h0);
		ce <= 1'b1;
		i_rstn <= 1'b0;
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		rd_chk(OFS_CFG, 32'h0, RESP_OKAY);
		chk_after(48'h0, 32'h0);
		cmp_val(32'(upd_n), 32'h0);
		final_report();
	end
endmodule
